// file: rtl/sync_burst_sram_control.sv
// control logic of a flow-through synchronous burst sram, 64K x 18
// assumes all pins except output enable and order strap are synchronous to clk
module sync_burst_sram_control #(
    parameter int ADDR_W = sram_ctl_pkg::ADDR_W,
    parameter int LANE_W = sram_ctl_pkg::LANE_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] word_addr_in,
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_depth_hi,
    input wire logic chip_sel_depth_n,
    input wire logic cpu_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic write_enable_n,
    input wire logic all_lanes_write_n,
    input wire logic lane_a_write_n,
    input wire logic lane_b_write_n,
    input wire logic burst_order_strap,
    input wire logic output_enable_n,
    input wire sram_ctl_pkg::lanes_s data_io_lanes_in,
    output sram_ctl_pkg::lanes_s data_io_lanes_out,
    output logic [sram_ctl_pkg::LANES-1:0] data_io_lanes_oe_n,
    output sram_ctl_pkg::cycle_e access_cycle,
    output logic [ADDR_W-1:0] access_addr,
    output logic selected
);
    localparam int BURST_W = sram_ctl_pkg::BURST_W;
    localparam int UPPER_W = ADDR_W - BURST_W;
    localparam int LANES = sram_ctl_pkg::LANES;

    // lane write decode, shared by both lanes
    function automatic logic lane_write(
        input logic global_n,
        input logic enable_n,
        input logic lane_n
    );
        lane_write = !global_n || (!enable_n && !lane_n); // R9 R8 R10
    endfunction

    // grouped views of the control pins
    sram_ctl_pkg::burst_ctl_s bctl;
    sram_ctl_pkg::write_ctl_s wctl;
    assign bctl.cpu_addr_strobe_n = cpu_addr_strobe_n;
    assign bctl.ctrl_addr_strobe_n = ctrl_addr_strobe_n;
    assign bctl.burst_step_n = burst_step_n;
    assign bctl.chip_sel_primary_n = chip_sel_primary_n;
    assign bctl.chip_sel_depth_hi = chip_sel_depth_hi;
    assign bctl.chip_sel_depth_n = chip_sel_depth_n;
    assign wctl.all_lanes_write_n = all_lanes_write_n;
    assign wctl.write_enable_n = write_enable_n;
    assign wctl.lane_b_write_n = lane_b_write_n;
    assign wctl.lane_a_write_n = lane_a_write_n;

    // registered state
    logic active_reg;
    logic [UPPER_W-1:0] upper_reg;
    logic [BURST_W-1:0] low_reg;
    sram_ctl_pkg::cycle_e cycle_reg;
    logic read_drive_reg;

    logic active_next;
    logic [UPPER_W-1:0] upper_next;
    sram_ctl_pkg::cycle_e cycle_next;
    logic read_drive_next;

    // selection and strobe decode
    wire depth_ok;
    wire chip_ok;
    wire cpu_start;
    wire ctrl_start;
    wire any_start;
    wire start_select;
    wire start_deselect;
    wire burst_go;
    wire step_now;
    wire interleave;

    assign depth_ok = bctl.chip_sel_depth_hi && !bctl.chip_sel_depth_n; // R14
    assign chip_ok = !bctl.chip_sel_primary_n && depth_ok; // R14
    // cpu strobe counts only while the primary select is low
    assign cpu_start = !bctl.cpu_addr_strobe_n && !bctl.chip_sel_primary_n; // R11 R13
    // controller strobe acts regardless of the primary select
    assign ctrl_start = !bctl.ctrl_addr_strobe_n && !cpu_start; // R12
    assign any_start = cpu_start || ctrl_start; // R4
    assign start_select = any_start && chip_ok; // R4 R14
    assign start_deselect = any_start && !chip_ok; // R13 R11 R12
    assign burst_go = !any_start && active_reg;
    assign step_now = burst_go && !bctl.burst_step_n; // R6
    // strap is used live, never registered
    assign interleave = (burst_order_strap != sram_ctl_pkg::STRAP_LINEAR); // R5 R15

    // write decode
    wire lane_a_sel;
    wire lane_b_sel;
    wire write_req;
    wire write_allowed;
    wire [LANES-1:0] lane_we;

    assign lane_a_sel = lane_write(wctl.all_lanes_write_n, wctl.write_enable_n,
        wctl.lane_a_write_n); // R8 R9 R10
    assign lane_b_sel = lane_write(wctl.all_lanes_write_n, wctl.write_enable_n,
        wctl.lane_b_write_n); // R8 R9 R10
    assign write_req = lane_a_sel || lane_b_sel;
    // a cpu-strobe cycle always begins as a read; the write follows it
    assign write_allowed = (start_select && ctrl_start) || burst_go;
    assign lane_we[sram_ctl_pkg::LANE_A] = write_allowed && lane_a_sel; // R7
    assign lane_we[sram_ctl_pkg::LANE_B] = write_allowed && lane_b_sel; // R7

    // address path
    wire [BURST_W-1:0] low_next;
    wire [ADDR_W-1:0] array_addr;

    burst_low_counter #(
        .BURST_W(BURST_W)
    ) u_counter (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .load(start_select),
        .step(step_now),
        .interleave(interleave),
        .load_bits(word_addr_in[BURST_W-1:0]), // R17
        .next_bits(low_next)
    ); // R3

    assign upper_next = start_select ? word_addr_in[ADDR_W-1:BURST_W] : upper_reg; // R4 R24
    assign array_addr = {upper_next, low_next}; // R2

    // cycle state decode
    always_comb begin
        active_next = active_reg;
        cycle_next = cycle_reg;
        read_drive_next = 1'b0;
        case (cycle_reg)
            sram_ctl_pkg::CYC_IDLE,
            sram_ctl_pkg::CYC_READ,
            sram_ctl_pkg::CYC_WRITE: begin
                if (start_deselect) begin
                    active_next = 1'b0; // R13
                    cycle_next = sram_ctl_pkg::CYC_IDLE;
                end else if (start_select) begin
                    active_next = 1'b1;
                    if (ctrl_start && write_req) begin
                        cycle_next = sram_ctl_pkg::CYC_WRITE;
                    end else begin
                        cycle_next = sram_ctl_pkg::CYC_READ;
                        read_drive_next = 1'b1;
                    end
                end else if (active_reg) begin
                    // continue or suspend at next or current address
                    if (write_req) begin
                        cycle_next = sram_ctl_pkg::CYC_WRITE;
                    end else begin
                        cycle_next = sram_ctl_pkg::CYC_READ;
                        read_drive_next = 1'b1; // R24
                    end
                end else begin
                    cycle_next = sram_ctl_pkg::CYC_IDLE;
                end
            end
            default: begin
                active_next = 1'b0;
                cycle_next = sram_ctl_pkg::CYC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            active_reg <= 1'b0;
            cycle_reg <= sram_ctl_pkg::CYC_IDLE;
            read_drive_reg <= 1'b0;
        end else if (ce) begin
            active_reg <= active_next; // R2
            cycle_reg <= cycle_next;
            read_drive_reg <= read_drive_next;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            upper_reg <= sram_ctl_pkg::UPPER_RST;
            low_reg <= sram_ctl_pkg::BURST_RST;
        end else if (ce) begin
            upper_reg <= upper_next; // R2
            low_reg <= low_next;
        end
    end

    // storage; read data come straight from the array register
    logic [LANES*LANE_W-1:0] rd_word;

    sram_word_array #(
        .ADDR_W(ADDR_W),
        .LANE_W(LANE_W),
        .LANES(LANES)
    ) u_array (
        .clk(clk),
        .ce(ce),
        .addr(array_addr),
        .lane_we(lane_we),
        .wr_data(data_io_lanes_in), // R2
        .rd_data(rd_word)
    ); // R1

    assign data_io_lanes_out = rd_word; // R18

    // output enable is asynchronous and only gates the registered read state
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gen_oe
            assign data_io_lanes_oe_n[g] = output_enable_n || !read_drive_reg; // R16 R23
        end
    endgenerate

    assign access_cycle = cycle_reg;
    assign access_addr = {upper_reg, low_reg};
    assign selected = active_reg;
endmodule

// file: rtl/sram_ctl_pkg.sv
// constants, types and reset values for the burst sram control block
// assumes one clock, synchronous active-high reset and a clock enable
// Contract
// R1 - array holds 64K words of 18 bits each
// R2 - address, data and controls captured at rising edge; enable and strap not
// R3 - a 2-bit counter supplies the two low address bits during bursts
// R4 - either address strobe starts a burst by loading the external address
// R5 - strap low gives linear order, strap high gives interleaved order
// R6 - burst step input advances the counter in the selected order
// R7 - writes start at the clock edge and need no external pulse
// R8 - write enable plus a lane's byte write writes that lane only
// R9 - global write writes both lanes, overriding byte writes and enable
// R10 - write enable with both byte writes writes both lanes
// R11 - cpu strobe starts a cycle but is ignored while primary select is high
// R12 - controller strobe starts a cycle whatever the primary select is
// R13 - primary select high blocks cpu strobe, deselects on controller strobe
// R14 - selection also needs depth select high and second depth select low
// R15 - the system holds the burst order strap fixed during operation
// R16 - output enable acts without the clock; high releases the data pins
// R17 - the controller wires the two low address inputs to its address LSBs
// R18 - read data reaches the outputs without an output register
// R19 - a byte-write-only controller ties write enable low
// R20 - a byte-write-only controller ties global write high
// R21 - linear order counts low bits upward from loaded value, modulo four
// R22 - interleaved order xors loaded low bits with 01, 10, 11 in turn
// R23 - controller negates output enable around a write that follows a read
// R24 - with no new access and no step, the current address repeats
// R25 - an accepted strobe cycle restarts the counter at the loaded bits
package sram_ctl_pkg;
    localparam int ADDR_W = 16;
    localparam int WORD_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int BURST_W = 2;
    localparam int UPPER_W = ADDR_W - BURST_W;
    localparam int LANE_A = 0;
    localparam int LANE_B = 1;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
    localparam logic [UPPER_W-1:0] UPPER_RST = 14'h0000;
    localparam logic [LANE_W-1:0] LANE_RST = 9'h000;
    localparam logic STRAP_LINEAR = 1'b0;

    typedef enum logic [2:0] {
        CYC_IDLE = 3'b001,
        CYC_READ = 3'b010,
        CYC_WRITE = 3'b100
    } cycle_e;

    typedef struct packed {
        logic [LANE_W-1:0] lane_b;
        logic [LANE_W-1:0] lane_a;
    } lanes_s;

    typedef struct packed {
        logic cpu_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_step_n;
        logic chip_sel_primary_n;
        logic chip_sel_depth_hi;
        logic chip_sel_depth_n;
    } burst_ctl_s;

    typedef struct packed {
        logic all_lanes_write_n;
        logic write_enable_n;
        logic lane_b_write_n;
        logic lane_a_write_n;
    } write_ctl_s;
endpackage

// file: rtl/sram_word_array.sv
// synchronous word array with per-lane write and registered read data
// assumes read and write addresses are presented ahead of the clock edge
module sram_word_array #(
    parameter int ADDR_W = sram_ctl_pkg::ADDR_W,
    parameter int LANE_W = sram_ctl_pkg::LANE_W,
    parameter int LANES = sram_ctl_pkg::LANES
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] lane_we,
    input wire logic [LANES*LANE_W-1:0] wr_data,
    output logic [LANES*LANE_W-1:0] rd_data
);
    localparam int DEPTH = 1 << ADDR_W;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gen_lane
            logic [LANE_W-1:0] mem [DEPTH]; // R1
            always_ff @(posedge clk) begin
                if (ce && lane_we[g]) begin
                    mem[addr] <= wr_data[g*LANE_W +: LANE_W];
                end
            end
            // written lanes read back the new value in the same cycle
            always_ff @(posedge clk) begin
                if (ce) begin
                    rd_data[g*LANE_W +: LANE_W] <= lane_we[g] ?
                        wr_data[g*LANE_W +: LANE_W] : mem[addr];
                end
            end
        end
    endgenerate
endmodule

// file: rtl/burst_low_counter.sv
// two-bit burst counter giving the low address bits in linear or interleaved order
// assumes the order strap is static while bursts run
module burst_low_counter #(
    parameter int BURST_W = sram_ctl_pkg::BURST_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic load,
    input wire logic step,
    input wire logic interleave,
    input wire logic [BURST_W-1:0] load_bits,
    output logic [BURST_W-1:0] next_bits
);
    logic [BURST_W-1:0] base_reg;
    logic [BURST_W-1:0] count_reg;
    logic [BURST_W-1:0] base_next;
    logic [BURST_W-1:0] count_next;

    assign base_next = load ? load_bits : base_reg; // R4
    assign count_next = load ? sram_ctl_pkg::BURST_RST : // R25
        (step ? BURST_W'(count_reg + sram_ctl_pkg::BURST_ONE) : count_reg); // R6 R24
    // linear adds the count, interleaved xors it
    assign next_bits = interleave ? (base_next ^ count_next) : // R22 R5
        BURST_W'(base_next + count_next); // R21

    always_ff @(posedge clk) begin
        if (reset) begin
            base_reg <= sram_ctl_pkg::BURST_RST;
            count_reg <= sram_ctl_pkg::BURST_RST;
        end else if (ce) begin
            base_reg <= base_next; // R3
            count_reg <= count_next;
        end
    end
endmodule

// file: tb/sram_ctl_props.sv
// pin-level assertions for the burst sram control block
// assumes one clock and a synchronous active-high reset
module sram_ctl_props #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] word_addr_in,
    input wire logic chip_sel_primary_n,
    input wire logic chip_sel_depth_hi,
    input wire logic chip_sel_depth_n,
    input wire logic cpu_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic all_lanes_write_n,
    input wire logic burst_order_strap,
    input wire logic output_enable_n,
    input wire logic [1:0] data_io_lanes_oe_n,
    input wire sram_ctl_pkg::cycle_e access_cycle,
    input wire logic [ADDR_W-1:0] access_addr,
    input wire logic selected
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire start = (!cpu_addr_strobe_n && !chip_sel_primary_n) || !ctrl_addr_strobe_n;
    wire ok = !chip_sel_primary_n && chip_sel_depth_hi && !chip_sel_depth_n;
    wire cont = ce && !start && selected;
    property p_oe_async;
        output_enable_n |-> data_io_lanes_oe_n == 2'h3;
    endproperty
    a_oe_async: assert property (p_oe_async) else $error("pins driven with enable high");
    property p_cpu_blocked;
        ce && !selected && !cpu_addr_strobe_n && chip_sel_primary_n && ctrl_addr_strobe_n
            |=> access_cycle == sram_ctl_pkg::CYC_IDLE;
    endproperty
    a_cpu_blocked: assert property (p_cpu_blocked) else $error("blocked strobe started");
    property p_ctrl_desel;
        ce && !ctrl_addr_strobe_n && chip_sel_primary_n
            |=> !selected && access_cycle == sram_ctl_pkg::CYC_IDLE;
    endproperty
    a_ctrl_desel: assert property (p_ctrl_desel) else $error("no deselect");
    property p_depth;
        ce && start && (!chip_sel_depth_hi || chip_sel_depth_n) |=> !selected;
    endproperty
    a_depth: assert property (p_depth) else $error("selected without depth selects");
    property p_load;
        ce && start && ok |=> selected && access_addr == $past(word_addr_in);
    endproperty
    a_load: assert property (p_load) else $error("external address not loaded");
    property p_cpu_read;
        ce && !cpu_addr_strobe_n && ok |=> access_cycle == sram_ctl_pkg::CYC_READ;
    endproperty
    a_cpu_read: assert property (p_cpu_read) else $error("cpu start not a read");
    property p_step;
        cont && !burst_step_n && burst_order_strap == sram_ctl_pkg::STRAP_LINEAR
            |=> access_addr[1:0] == $past(access_addr[1:0]) + 2'h1
            && access_addr[ADDR_W-1:2] == $past(access_addr[ADDR_W-1:2]);
    endproperty
    a_step: assert property (p_step) else $error("linear step wrong");
    property p_hold;
        cont && burst_step_n |=> $stable(access_addr) && selected;
    endproperty
    a_hold: assert property (p_hold) else $error("suspend moved address");
    property p_write;
        cont && !all_lanes_write_n
            |=> access_cycle == sram_ctl_pkg::CYC_WRITE && data_io_lanes_oe_n == 2'h3;
    endproperty
    a_write: assert property (p_write) else $error("global write not taken");
    property p_freeze;
        !ce |=> $stable(access_addr) && $stable(access_cycle) && $stable(selected);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule
bind sync_burst_sram_control sram_ctl_props #(.ADDR_W(ADDR_W)) sram_ctl_props_inst (
    .clk(clk), .reset(reset), .ce(ce), .word_addr_in(word_addr_in),
    .chip_sel_primary_n(chip_sel_primary_n), .chip_sel_depth_hi(chip_sel_depth_hi),
    .chip_sel_depth_n(chip_sel_depth_n), .cpu_addr_strobe_n(cpu_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_step_n(burst_step_n),
    .all_lanes_write_n(all_lanes_write_n), .burst_order_strap(burst_order_strap),
    .output_enable_n(output_enable_n), .data_io_lanes_oe_n(data_io_lanes_oe_n),
    .access_cycle(access_cycle), .access_addr(access_addr), .selected(selected));

// file: tb/cache_ctl_model.sv
// model of the cache controller that drives the burst sram pins
// assumes drive is called once per cycle just after the rising edge
module cache_ctl_model (
    input wire logic clk,
    output sram_ctl_pkg::burst_ctl_s bc,
    output sram_ctl_pkg::write_ctl_s wc,
    output logic [15:0] addr,
    output sram_ctl_pkg::lanes_s wdata,
    output logic oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bc = '1;
        wc = '1;
        addr = 16'h0000;
        wdata = '0;
        oe_n = 1'b1;
    end
    task automatic drive(input sram_ctl_pkg::burst_ctl_s b, input sram_ctl_pkg::write_ctl_s w,
                         input logic [15:0] a, input logic [17:0] d, input logic o);
        logic wr;
        wr = !w.all_lanes_write_n || (!w.write_enable_n && !(w.lane_a_write_n && w.lane_b_write_n));
        bc = b;
        wc = w;
        addr = a;
        wdata = d;
        // enable stays negated across the whole cycle of a write
        oe_n = o | wr;
        @(posedge clk);
        #1;
    endtask
endmodule

// file: tb/sync_burst_sram_control_tb.sv
// self-checking bench for the burst sram control block
// assumes the controller model drives all pins one step after the clock edge
module sync_burst_sram_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        sram_ctl_pkg::cycle_e cyc;
        logic [15:0] addr;
        logic [17:0] data;
    } note_s;
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, strap = 1'b0, oe_in, active = 1'b0, sel;
    sram_ctl_pkg::burst_ctl_s bc;
    sram_ctl_pkg::write_ctl_s wc;
    sram_ctl_pkg::lanes_s wdata, rdata;
    sram_ctl_pkg::cycle_e cyc;
    logic [15:0] addr, acc_addr, base, b0;
    logic [1:0] cnt, oe_n;
    logic [17:0] mem [int];
    note_s notes[$];
    int miscompares = 0, check_count = 0;
    cache_ctl_model cache_ctl_model_inst (.clk(clk), .bc(bc), .wc(wc), .addr(addr),
        .wdata(wdata), .oe_n(oe_in));
    sync_burst_sram_control sync_burst_sram_control_inst (.clk(clk), .reset(reset), .ce(ce),
        .word_addr_in(addr), .chip_sel_primary_n(bc.chip_sel_primary_n),
        .chip_sel_depth_hi(bc.chip_sel_depth_hi), .chip_sel_depth_n(bc.chip_sel_depth_n),
        .cpu_addr_strobe_n(bc.cpu_addr_strobe_n), .ctrl_addr_strobe_n(bc.ctrl_addr_strobe_n),
        .burst_step_n(bc.burst_step_n), .write_enable_n(wc.write_enable_n),
        .all_lanes_write_n(wc.all_lanes_write_n), .lane_a_write_n(wc.lane_a_write_n),
        .lane_b_write_n(wc.lane_b_write_n), .burst_order_strap(strap),
        .output_enable_n(oe_in), .data_io_lanes_in(wdata), .data_io_lanes_out(rdata),
        .data_io_lanes_oe_n(oe_n), .access_cycle(cyc), .access_addr(acc_addr),
        .selected(sel));
    initial forever #20 clk = ~clk;
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one note per cycle, compared half a clock after the edge that took it
    always @(negedge clk) begin
        note_s n;
        logic [1:0] oe_exp;
        if (notes.size() > 0) begin
            n = notes.pop_front();
            // output enable acts at once, so the level now on the pin decides
            oe_exp = (n.cyc == sram_ctl_pkg::CYC_READ && !oe_in) ? 2'h0 : 2'h3;
            check("cycle", cyc, n.cyc);
            check("selected", sel, n.cyc != sram_ctl_pkg::CYC_IDLE);
            check("lanes_oe_n", oe_n, oe_exp);
            if (n.cyc != sram_ctl_pkg::CYC_IDLE) check("addr", acc_addr, n.addr);
            if (n.cyc == sram_ctl_pkg::CYC_READ) check("rdata", rdata, n.data);
        end
    end
    task automatic op(input logic cpu_n, ctrl_n, step_n, input logic [2:0] s, input logic [3:0] w,
                      input logic [15:0] a, input logic o);
        note_s n;
        logic st, cs;
        logic [1:0] lw;
        logic [17:0] d, old;
        d = 18'($urandom);
        cs = !cpu_n && !s[2];
        st = cs || !ctrl_n;
        lw = {!w[3] | (!w[2] & !w[1]), !w[3] | (!w[2] & !w[0])};
        if (st) begin
            active = (s == 3'h2);
            base = a;
            cnt = 2'h0;
        end else if (active && !step_n) cnt++;
        n.addr = {base[15:2], strap ? base[1:0] ^ cnt : base[1:0] + cnt};
        n.cyc = !active ? sram_ctl_pkg::CYC_IDLE
              : (lw != 2'h0 && !cs) ? sram_ctl_pkg::CYC_WRITE : sram_ctl_pkg::CYC_READ;
        old = mem.exists(n.addr) ? mem[n.addr] : 'x;
        if (n.cyc == sram_ctl_pkg::CYC_WRITE)
            old = {lw[1] ? d[17:9] : old[17:9], lw[0] ? d[8:0] : old[8:0]};
        mem[n.addr] = old;
        n.data = old;
        cache_ctl_model_inst.drive({cpu_n, ctrl_n, step_n, s}, w, a, d, o);
        // noted once the edge that takes the request has passed
        notes.push_back(n);
    endtask
    task automatic do_reset;
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        active = 1'b0;
    endtask
    initial begin
        void'($urandom(32'h4903));
        do_reset;
        check("selected", sel, 1'b0);
        b0 = 16'($urandom);
        b0[1:0] = 2'h2;
        op(1, 0, 1, 3'h2, 4'h7, b0, 1);
        repeat (3) op(1, 1, 0, 3'h7, 4'h7, 16'($urandom), 1);
        op(0, 1, 0, 3'h2, 4'h0, {b0[15:2], 2'h3}, 1);
        op(1, 1, 0, 3'h7, 4'hF, 16'($urandom), 0);
        op(1, 1, 1, 3'h7, 4'hF, 16'($urandom), 0);
        repeat (2) op(1, 1, 0, 3'h7, 4'hF, 16'($urandom), 0);
        op(0, 1, 1, 3'h6, 4'hF, 16'($urandom), 0);
        op(1, 0, 1, 3'h0, 4'hF, b0, 0);
        op(0, 1, 1, 3'h6, 4'hF, b0, 0);
        op(0, 1, 1, 3'h3, 4'hF, b0, 0);
        op(0, 1, 1, 3'h2, 4'hF, b0, 1);
        op(1, 0, 1, 3'h6, 4'hF, b0, 0);
        for (int i = 0; i < 16; i++) op(1, 0, 1, 3'h2, 4'(i), {b0[15:2], 2'(i)}, 1);
        // byte-write-only controller: global write held high, write enable held low
        for (int i = 0; i < 4; i++) begin
            op(1, 0, 1, 3'h2, {2'h2, 2'(i)}, {b0[15:2], 2'(i)}, 1);
        end
        // one edge with the clock enable low must leave everything in place
        ce = 1'b0;
        @(posedge clk);
        #1;
        ce = 1'b1;
        check("frozen_addr", acc_addr, {b0[15:2], 2'h3});
        for (int i = 0; i < 4; i++) op(0, 1, 1, 3'h2, 4'hF, {b0[15:2], 2'(i)}, 0);
        // order strap only moves while the block is held in reset
        strap = 1'b1;
        do_reset;
        op(0, 1, 0, 3'h2, 4'hF, {b0[15:2], 2'h1}, 0);
        repeat (2) op(1, 1, 0, 3'h7, 4'hF, 16'($urandom), 0);
        op(1, 0, 0, 3'h2, 4'hF, {b0[15:2], 2'h2}, 0);
        repeat (3) op(1, 1, 0, 3'h7, 4'hF, 16'($urandom), 0);
        repeat (2) @(posedge clk);
        conclude;
    end
    initial begin
        #20000;
        miscompares++;
        conclude;
    end
endmodule
